/* File: hw/twesp_core.sv */
// Purpose: two-wire slave port with page buffer and 512-byte array
// Assumes: scl_i is the link clock; sda is open drain (o/oe split)
// Notes: array is written only while busy, when the link ignores the bus
// Notes: link flops clear at once in reset, scl may stand still then
// Notes: the array keeps its contents through reset
// Notes: a write needs one full acked data byte before its stop
`timescale 1ns/10ps
`default_nettype none

module twesp_core
  import twesp_pkg::*;
#(
  parameter int unsigned TWR_CYCLES = `TWESP_TWR_NS / `TWESP_CLK_NS
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic wp_upper_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic busy_o
);

  logic [7:0] mem [`TWESP_MEM_BYTES];
  logic start_tgl;
  logic stop_tgl;
  twesp_link_t lq;
  twesp_link_t next_lq;
  twesp_sys_t sq;
  twesp_sys_t next_sq;
  logic oe;
  logic next_oe;
  logic busy;
  logic commit_ok;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;
  logic type_match;
  logic sel_match;
  logic addr_hit;
  logic wp_block;
  logic ack_slot;
  logic last_bit;
  logic in_read;
  logic frame_new;
  logic [2:0] bit_sel;
  logic out_bit;
  logic data_oe;
  logic [`TWESP_ADDR_W-1:0] addr_inc;
  logic [`TWESP_ADDR_W-1:0] page_inc;
  logic stop_new;
  logic copy_done;
  logic wait_done;
  logic wr_en;
  logic [`TWESP_IDX_W-1:0] next_idx;

  always_ff @(negedge sda_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      start_tgl <= 1'b0;
    else if (scl_i)
      start_tgl <= ~start_tgl;
  end

  always_ff @(posedge sda_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      stop_tgl <= 1'b0;
    else if (scl_i)
      stop_tgl <= ~stop_tgl;
  end

  assign byte_in = {lq.shreg[6:0], sda_i};
  // array is static whenever the link may read it (not busy)
  assign rd_byte = mem[lq.addr];

  // slave address compare on the byte now complete
  assign type_match = (byte_in[7:4] == `TWESP_DEV_TYPE);
  assign sel_match = (byte_in[3:2] == `TWESP_SEL_BITS);
  // a busy array never answers its address
  assign addr_hit = type_match && sel_match && !lq.busy_sync;
  // only the upper half can be locked
  assign wp_block = lq.wp_sync && lq.pg.page[4];
  assign ack_slot = (lq.bitcnt == `TWESP_ACK_SLOT);
  assign last_bit = (lq.bitcnt == `TWESP_LAST_BIT);
  assign in_read = (lq.st == L_READ);
  // a start toggle not yet taken opens a frame
  assign frame_new = (start_tgl != lq.start_seen);
  // counter points one past the byte last touched
  assign addr_inc = lq.addr + 9'h001;
  // low four bits roll over, page bits never carry
  assign page_inc = {lq.pg.page, lq.addr[3:0] + 4'h1};
  assign bit_sel = ~lq.bitcnt[2:0];
  assign out_bit = lq.shreg[bit_sel];
  // read bits pull low only in the eight data clocks
  assign data_oe = in_read && (lq.bitcnt < `TWESP_ACK_SLOT) && !out_bit;

  // link side: start toggle compared directly, it settles half a bit
  // before the next scl rise, so no extra synchroniser delay is needed
  always_comb
  begin
    next_lq = lq;
    next_lq.busy_meta = busy;
    next_lq.busy_sync = lq.busy_meta;
    next_lq.wp_meta = wp_upper_i;
    next_lq.wp_sync = lq.wp_meta;
    if (frame_new)
    begin
      // new frame; this rise holds address msb
      next_lq.start_seen = start_tgl;
      next_lq.st = L_ADDR;
      next_lq.bitcnt = 4'h1;
      next_lq.shreg = {7'h00, sda_i};
      next_lq.ack_now = 1'b0;
    end
    else if (lq.st == L_IDLE)
    begin
      next_lq.bitcnt = 4'h0;
    end
    else if (ack_slot)
    begin
      next_lq.bitcnt = 4'h0;
      next_lq.ack_now = 1'b0;
      case (lq.st)
        L_ADDR:
        begin
          if (!lq.ack_now)
            next_lq.st = L_IGNORE;
          else if (lq.rw)
          begin
            next_lq.st = L_READ;
            next_lq.shreg = rd_byte;
            next_lq.addr = addr_inc;
          end
          else
            next_lq.st = L_WORD;
        end
        L_WORD:
        begin
          next_lq.addr = {lq.a8, lq.shreg};
          next_lq.pg.page = {lq.a8, lq.shreg[7:4]};
          next_lq.pg.mask = '0;
          next_lq.have_data = 1'b0;
          next_lq.st = L_DATA;
        end
        L_DATA:
        begin
          if (lq.ack_now)
          begin
            next_lq.pg.data[lq.addr[3:0]] = lq.shreg;
            next_lq.pg.mask[lq.addr[3:0]] = 1'b1;
            next_lq.have_data = 1'b1;
            next_lq.addr = page_inc;
          end
          else
            next_lq.st = L_IGNORE;
        end
        L_READ:
        begin
          if (!sda_i)
          begin
            next_lq.shreg = rd_byte;
            next_lq.addr = addr_inc;
          end
          else
            next_lq.st = L_IGNORE;
        end
        default:
          next_lq.st = L_IGNORE;
      endcase
    end
    else
    begin
      next_lq.bitcnt = lq.bitcnt + 4'h1;
      if (!in_read)
        next_lq.shreg = byte_in;
      if (last_bit)
      begin
        case (lq.st)
          L_ADDR:
          begin
            next_lq.ack_now = addr_hit;
            next_lq.rw = byte_in[0];
            next_lq.a8 = byte_in[1];
          end
          L_WORD:
            next_lq.ack_now = 1'b1;
          L_DATA:
            next_lq.ack_now = !wp_block;
          default:
            next_lq.ack_now = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge scl_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      lq <= '0;
    else
      lq <= next_lq;
  end

  // ack in ninth clock, read bits in the first eight
  always_comb
  begin
    next_oe = 1'b0;
    if (ack_slot)
      next_oe = lq.ack_now;
    else
      next_oe = data_oe;
  end

  // drive changes on scl fall only
  always_ff @(negedge scl_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      oe <= 1'b0;
    else
      oe <= next_oe;
  end

  // commit only right after an acked data byte
  assign commit_ok = (lq.st == L_DATA) && lq.have_data &&
                     (lq.bitcnt == `TWESP_STOP_SLOT);

  // a stop not yet taken by the write cycle logic
  assign stop_new = (sq.stop_dly != sq.stop_seen);
  assign copy_done = (sq.idx == `TWESP_LAST_IDX);
  assign next_idx = sq.idx + 4'h1;
  // write time counted in system clocks
  assign wait_done = (sq.timer >= TWR_CYCLES - 32'h0000_0001);
  // copy writes only the slots the master filled
  assign wr_en = (sq.st == S_COPY) && lq.pg.mask[sq.idx];

  // system side: stop toggle gets one extra stage so the commit level,
  // settled before the stop edge, is surely through its own pair
  always_comb
  begin
    next_sq = sq;
    next_sq.stop_meta = stop_tgl;
    next_sq.stop_sync = sq.stop_meta;
    next_sq.stop_dly = sq.stop_sync;
    next_sq.cmt_meta = commit_ok;
    next_sq.cmt_sync = sq.cmt_meta;
    if (stop_new)
      next_sq.stop_seen = sq.stop_dly;
    case (sq.st)
      S_IDLE:
      begin
        if (stop_new && sq.cmt_sync)
        begin
          next_sq.st = S_COPY;
          next_sq.idx = 4'h0;
        end
      end
      S_COPY:
      begin
        next_sq.idx = next_idx;
        if (copy_done)
        begin
          next_sq.st = S_WAIT;
          next_sq.timer = 32'h0000_0000;
        end
      end
      S_WAIT:
      begin
        next_sq.timer = sq.timer + 32'h0000_0001;
        if (wait_done)
          next_sq.st = S_IDLE;
      end
      default:
        next_sq.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      sq <= '0;
    else
      sq <= next_sq;
  end

  // page buffer is frozen: link only refills it after a new word address
  always_ff @(posedge clk_sys_i)
  begin
    if (wr_en)
      mem[{lq.pg.page, sq.idx}] <= lq.pg.data[sq.idx];
  end

  assign busy = (sq.st != S_IDLE);
  assign busy_o = busy;
  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = oe;

endmodule : twesp_core

`default_nettype wire

/* File: hw/twesp_defs.svh */
// Purpose: constants of the two-wire memory slave port
// Assumes: included by the package only; the core relies on that include
// Notes: times in ns; cycle counts derive from them in the core
`ifndef TWESP_DEFS_SVH
`define TWESP_DEFS_SVH

`define TWESP_DEV_TYPE 4'hA
`define TWESP_SEL_BITS 2'h0
`define TWESP_ADDR_W 9
`define TWESP_PAGE_W 5
`define TWESP_IDX_W 4
`define TWESP_PAGE_BYTES 16
`define TWESP_MEM_BYTES 512
`define TWESP_ACK_SLOT 4'h8
`define TWESP_LAST_BIT 4'h7
`define TWESP_STOP_SLOT 4'h1
`define TWESP_LAST_IDX 4'hF
`define TWESP_CLK_NS 50
`define TWESP_TWR_NS 5000000

`endif

/* File: hw/twesp_pkg.sv */
// Purpose: types shared by the two-wire memory slave port
// Assumes: twesp_defs.svh gives widths
// Notes: one state struct per clock domain
`include "twesp_defs.svh"

package twesp_pkg;

  typedef enum logic [2:0] {
    L_IDLE,
    L_ADDR,
    L_WORD,
    L_DATA,
    L_READ,
    L_IGNORE
  } twesp_lst_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_COPY,
    S_WAIT
  } twesp_sst_t;

  typedef struct packed {
    logic [`TWESP_PAGE_W-1:0] page;
    logic [`TWESP_PAGE_BYTES-1:0] mask;
    logic [`TWESP_PAGE_BYTES-1:0][7:0] data;
  } twesp_page_t;

  typedef struct packed {
    logic busy_meta;
    logic busy_sync;
    logic wp_meta;
    logic wp_sync;
    twesp_lst_t st;
    logic start_seen;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic a8;
    logic ack_now;
    logic have_data;
    logic [`TWESP_ADDR_W-1:0] addr;
    twesp_page_t pg;
  } twesp_link_t;

  typedef struct packed {
    logic stop_meta;
    logic stop_sync;
    logic stop_dly;
    logic stop_seen;
    logic cmt_meta;
    logic cmt_sync;
    twesp_sst_t st;
    logic [3:0] idx;
    logic [31:0] timer;
  } twesp_sys_t;

endpackage : twesp_pkg

/* File: verification/tb_top.sv */
// Purpose: self-checking bench of the slave port
// Assumes: master model drives scl and pulls sda low
// Notes: write time cut to 20 cycles (36-cycle write cycle with the copy) to keep the run short
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import twesp_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wp = 1'b0;
  logic scl, pull, oe, busy, sda_o;
  wire sda = !(pull | oe);
  int n_mismatch = 0;
  int num_checks = 0;
  twesp_core #(.TWR_CYCLES(20)) DUT (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .wp_upper_i(wp),
    .sda_o(sda_o), .sda_oe_o(oe), .busy_o(busy));
  twesp_master mst (.scl_o(scl), .pull_o(pull), .sda_i(sda));
  always #25 clk_sys_i = !clk_sys_i;
  task automatic check(input logic [8:0] s, input logic [8:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic wait_busy(input logic lvl);
    for (int n = 0; n < 200 && busy !== lvl; n++)
      @(negedge clk_sys_i);
    check(busy, lvl);
    if (busy !== lvl)
      end_of_test;
  endtask : wait_busy
  task automatic tx(input logic [7:0] d, input logic a);
    logic k;
    mst.wbyte(d, k);
    check(k, a);
  endtask : tx
  task automatic rx(input logic [7:0] e, input logic a);
    logic [7:0] d;
    mst.rbyte(a, d);
    check(d, e);
  endtask : rx
  task automatic rd_at(input logic [7:0] w);
    mst.start();
    tx(8'hA0, 1'b1);
    tx(w, 1'b1);
    mst.start();
    tx(8'hA1, 1'b1);
  endtask : rd_at
  task automatic t_write;
    mst.start();
    tx(8'hA4, 1'b0);
    mst.stop();
    mst.start();
    tx(8'hA0, 1'b1);
    tx(8'h20, 1'b1);
    tx(8'h5A, 1'b1);
    mst.stop();
    mst.start();
    tx(8'hA0, 1'b0);
    mst.stop();
    wait_busy(1'b0);
    rd_at(8'h20);
    rx(8'h5A, 1'b0);
    mst.stop();
    $display("byte write test done");
  endtask : t_write
  task automatic t_page;
    int j;
    mst.start();
    tx(8'hA0, 1'b1);
    tx(8'h1A, 1'b1);
    for (int k = 0; k < 18; k++)
      tx(8'(64 + k), 1'b1);
    mst.stop();
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd_at(8'h10);
    for (int k = 0; k < 16; k++)
    begin
      j = (k + 6) % 16;
      rx(8'(64 + j + (j < 2 ? 16 : 0)), 1'b1);
    end
    // next page holds the byte write; unwritten bytes would read unknown
    rx(8'h5A, 1'b0);
    mst.stop();
    $display("page write test done");
  endtask : t_page
  task automatic t_abort;
    logic r;
    mst.start();
    tx(8'hA0, 1'b1);
    tx(8'h20, 1'b1);
    for (int k = 0; k < 4; k++)
      mst.bit_x(1'b0, r);
    mst.stop();
    @(negedge clk_sys_i);
    wp = 1'b1;
    mst.start();
    tx(8'hA2, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'h77, 1'b0);
    mst.stop();
    @(negedge clk_sys_i);
    wp = 1'b0;
    rd_at(8'h20);
    rx(8'h5A, 1'b0);
    mst.stop();
    $display("abort test done");
  endtask : t_abort
  task automatic t_cur;
    mst.start();
    tx(8'hA0, 1'b1);
    tx(8'h1A, 1'b1);
    mst.stop();
    for (int k = 0; k < 2; k++)
    begin
      mst.start();
      tx(8'hA1, 1'b1);
      rx(8'(8'h50 + k), 1'b0);
      mst.stop();
    end
    $display("current read test done");
  endtask : t_cur
  initial
  begin
    repeat (8) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    t_write;
    t_page;
    t_abort;
    t_cur;
    end_of_test;
  end
endmodule : tb_top
`default_nettype wire

/* File: verification/twesp_core_assertions.sv */
// Purpose: bus-level checks of the slave port
// Assumes: bound to twesp_core
// Notes: link checks run on scl, write cycle checks on clk_sys
`timescale 1ns/10ps
`default_nettype none
module twesp_core_chk
  import twesp_pkg::*;
#(
  parameter int unsigned TWR_CYCLES = 20
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic busy_o
);
  logic [31:0] bcnt;
  logic oe_rise;
  logic started;
  always_ff @(posedge clk_sys_i)
  begin
    bcnt <= busy_o ? bcnt + 32'h1 : 32'h0;
  end
  // async clear: scl stands still in reset, no edge would clear it
  always_ff @(posedge scl_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      oe_rise <= 1'b0;
    else
      oe_rise <= sda_oe_o;
  end
  always_ff @(negedge sda_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      started <= 1'b0;
    else if (scl_i)
      started <= 1'b1;
  end
  sequence s_nine_drive;
    sda_oe_o [*8] ##1 sda_oe_o;
  endsequence
  sequence s_busy_hold;
    busy_o [*8];
  endsequence
  busy_quiet_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i) busy_o |-> !sda_oe_o)
    else $error("sda driven while busy");
  busy_len_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(busy_o) |-> bcnt == 32'(TWR_CYCLES + 16))
    else $error("write cycle length off");
  busy_min_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(busy_o) |=> s_busy_hold)
    else $error("write cycle cut short");
  no_start_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i) !started |-> !busy_o)
    else $error("write without a start");
  oe_steady_a: assert property (
    @(negedge scl_i) disable iff (!rst_n_i) sda_oe_o == oe_rise)
    else $error("sda drive moved while scl high");
  open_drain_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i) sda_o == 1'b0)
    else $error("sda driven high");
  ack_start_a: assert property (
    @(posedge scl_i) disable iff (!rst_n_i) sda_oe_o |-> started)
    else $error("answer before any start");
  read_release_a: assert property (
    @(posedge scl_i) disable iff (!rst_n_i) s_nine_drive |=> !sda_oe_o)
    else $error("sda held past ack slot");
endmodule : twesp_core_chk
bind twesp_core twesp_core_chk #(.TWR_CYCLES(TWR_CYCLES)) u_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_o(busy_o));
`default_nettype wire

/* File: verification/twesp_master.sv */
// Purpose: two-wire bus master model
// Assumes: the bench pulls sda up
// Notes: scl stands high between frames, 64 ns bit time
`timescale 1ns/10ps
`default_nettype none
module twesp_master
  import twesp_pkg::*;
(
  output var logic scl_o,
  output var logic pull_o,
  input wire logic sda_i
);
  initial
  begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  // sda moves only with scl low
  task automatic bit_x(input logic b, output logic r);
    pull_o = !b;
    #16 scl_o = 1'b1;
    #16 r = sda_i;
    #16 scl_o = 1'b0;
    #16;
  endtask : bit_x
  task automatic start;
    pull_o = 1'b0;
    #16 scl_o = 1'b1;
    #16 pull_o = 1'b1;
    #16 scl_o = 1'b0;
    #16;
  endtask : start
  task automatic stop;
    pull_o = 1'b1;
    #16 scl_o = 1'b1;
    #16 pull_o = 1'b0;
    #16;
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic ak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(!ak, r);
  endtask : rbyte
endmodule : twesp_master
`default_nettype wire
